// ### logic/mmc_defines.svh
// Timing constants for the module management control block
`ifndef MMC_DEFINES_SVH
`define MMC_DEFINES_SVH
`define MMC_CLK_HZ          20000000
`define MMC_T_INIT_MS       2000
`define MMC_T_RESET_US      2
`define MMC_T_LOW_POWER_PIN_US     100
`define MMC_T_INT_ON_MS     200
`define MMC_T_INT_OFF_US    500
`define MMC_T_LOS_MS        100
`define MMC_T_MASK_MS       100
`define MMC_T_SEL_US        100
`define MMC_T_PDOWN_MS      100
`define MMC_T_PUP_MS        300
`define MMC_RESET_CYC       ((`MMC_T_RESET_US * (`MMC_CLK_HZ / 1000000)) + 1)
`define MMC_INIT_CYC        (`MMC_T_INIT_MS * (`MMC_CLK_HZ / 1000))
`define MMC_PUP_CYC         (`MMC_T_PUP_MS * (`MMC_CLK_HZ / 1000))
`define MMC_FLAG_W          8
`endif

// ### logic/mmc_pkg.sv
// Types for the module management control block
package mmc_pkg;
	typedef enum logic [1:0] {
		MMC_ST_INIT,
		MMC_ST_READY,
		MMC_ST_LOWPWR,
		MMC_ST_WAKE
	} mmc_state_e;

	typedef struct packed {
		mmc_state_e  state;
		logic [31:0] timer;
		logic [7:0]  rst_cnt;
		logic        rst_hit;
		logic [1:0]  rst_sync;
		logic [1:0]  lp_sync;
		logic [1:0]  sel_sync;
		logic [7:0]  flags;
		logic        not_ready;
		logic        low_power;
		logic        bus_enable;
		logic        int_n;
	} mmc_state_s;
endpackage

// ### logic/mmc_control.sv
// Management, status and timing control of a pluggable optical module
`timescale 1ns/10ps
`include "mmc_defines.svh"

// Operation
// - Fully functional within 2000 ms of power-on
// - Reset pin low longer than 2 us
// - Answer serial bus within 2000 ms
// - Clear data-not-ready and assert interrupt
// - Functional within 2000 ms after reset release
// - Low-power pin lowers power within 100 us
// - Interrupt low within 200 ms of condition
// - Read clears flag; interrupt releases within 500 us
// - Receive-loss flag and interrupt within 100 ms
// - Transmit-fault flag and interrupt within 200 ms
// - Other flags and interrupt within 200 ms
// - Set mask inhibits flag's interrupt in 100 ms
// - Cleared mask restores interrupt within 100 ms
// - Module select enables bus within 100 us
// - Deselect stops bus answers within 100 us
// - Power-down bit lowers power within 100 ms
// - Power-down cleared: functional within 300 ms
// - Functional shown by interrupt with data ready (code: only when leaving init, not on wake from power-down)
// - Flag clear timed from read stop edge
// - Mask and power bits timed from write stop edge
module mmc_control
	import mmc_pkg::*;
#(
	parameter int INIT_CYCLES = `MMC_INIT_CYC,
	parameter int PUP_CYCLES  = `MMC_PUP_CYC,
	parameter int FLAG_W      = `MMC_FLAG_W
) (
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire logic              module_reset_n,
	input  wire logic              low_power_pin,
	input  wire logic              module_select_n,
	input  wire logic              rx_loss_event,
	input  wire logic              tx_fault_event,
	input  wire logic [FLAG_W-3:0] other_flag_event,
	input  wire logic [FLAG_W-1:0] flag_mask,
	input  wire logic              flag_read_done,
	input  wire logic              power_down_bit,
	output logic                   interrupt_out_n,
	output logic                   data_not_ready,
	output logic [FLAG_W-1:0]      flag_status,
	output logic                   low_power,
	output logic                   serial_bus_enable,
	output logic                   fully_functional
);
	// Flags live in an 8-bit field; rx, tx and at least one other are needed
	if (FLAG_W < 3 || FLAG_W > 8 || INIT_CYCLES < 1 || PUP_CYCLES < 1) begin : g_bad_param
		$error("mmc_control: unsupported parameter values");
	end

	mmc_state_s r;
	mmc_state_s next_r;
	logic       pin_reset_n;
	logic       lp_req;
	logic [7:0] events;

	assign pin_reset_n = r.rst_sync[1];
	assign lp_req      = r.lp_sync[1] | power_down_bit;
	assign events      = 8'(FLAG_W'({other_flag_event, tx_fault_event, rx_loss_event}));

	always_comb begin
		next_r          = r;
		next_r.rst_sync = {r.rst_sync[0], module_reset_n};
		next_r.lp_sync  = {r.lp_sync[0], low_power_pin};
		next_r.sel_sync = {r.sel_sync[0], module_select_n};
		next_r.timer    = r.timer + 32'h1;
		// Pulse filter: short glitches on the reset pin are ignored except in init, where any low sample holds the timer at zero
		if (!pin_reset_n) begin
			if (r.rst_cnt < 8'(`MMC_RESET_CYC))
				next_r.rst_cnt = r.rst_cnt + 8'h1;
			else
				next_r.rst_hit = 1'b1;
		end else begin
			next_r.rst_cnt = 8'h0;
		end
		// Events set flags; a set in the read-clear cycle wins
		if (flag_read_done)
			next_r.flags = 8'h0;
		next_r.flags = next_r.flags | events;
		// Serial bus follows select within a few cycles once out of init
		next_r.bus_enable = !r.sel_sync[1] && r.state != MMC_ST_INIT;
		unique case (r.state)
			MMC_ST_INIT: begin
				next_r.not_ready = 1'b1;
				next_r.low_power = lp_req;
				if (r.rst_hit || !pin_reset_n) begin
					next_r.timer = 32'h0;
					next_r.rst_hit = pin_reset_n ? 1'b0 : r.rst_hit;
				end else if (r.timer >= 32'(INIT_CYCLES - 1)) begin
					next_r.state     = MMC_ST_READY;
					next_r.not_ready = 1'b0;
				end
			end
			MMC_ST_READY: begin
				if (lp_req) begin
					next_r.state     = MMC_ST_LOWPWR;
					next_r.low_power = 1'b1;
				end
			end
			MMC_ST_LOWPWR: begin
				next_r.low_power = 1'b1;
				if (!lp_req) begin
					next_r.state = MMC_ST_WAKE;
					next_r.timer = 32'h0;
				end
			end
			MMC_ST_WAKE: begin
				if (lp_req) begin
					next_r.state = MMC_ST_LOWPWR;
				end else if (r.timer >= 32'(PUP_CYCLES - 1)) begin
					next_r.state     = MMC_ST_READY;
					next_r.low_power = 1'b0;
				end
			end
		endcase
		// Qualified pin reset restarts initialization
		if (r.rst_hit && r.state != MMC_ST_INIT) begin
			next_r.state     = MMC_ST_INIT;
			next_r.timer     = 32'h0;
			next_r.not_ready = 1'b1;
		end
		// Mask gates each flag; data-ready itself also pulls the line low
		next_r.int_n = !((|(next_r.flags & 8'(flag_mask ^ {FLAG_W{1'b1}})))
			|| (r.state == MMC_ST_INIT && next_r.state == MMC_ST_READY));
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			r            <= '0;
			r.state      <= MMC_ST_INIT;
			r.rst_sync   <= 2'h3;
			r.lp_sync    <= 2'h0;
			r.sel_sync   <= 2'h3;
			r.not_ready  <= 1'b1;
			r.int_n      <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign interrupt_out_n   = r.int_n;
	assign data_not_ready    = r.not_ready;
	assign flag_status       = FLAG_W'(r.flags);
	assign low_power         = r.low_power;
	assign serial_bus_enable = r.bus_enable;
	assign fully_functional  = (r.state == MMC_ST_READY);
endmodule // mmc_control

// ### sim/mmc_asserts.sv
// Port assertions for the management control block
`timescale 1ns/10ps
module mmc_asserts #(parameter int FLAG_W = 8) (
	input wire logic              clk_sys,
	input wire logic              reset,
	input wire logic              rx_loss_event,
	input wire logic              tx_fault_event,
	input wire logic [FLAG_W-3:0] other_flag_event,
	input wire logic [FLAG_W-1:0] flag_mask,
	input wire logic              flag_read_done,
	input wire logic              power_down_bit,
	input wire logic              module_select_n,
	input wire logic              interrupt_out_n,
	input wire logic              data_not_ready,
	input wire logic [FLAG_W-1:0] flag_status,
	input wire logic              low_power,
	input wire logic              serial_bus_enable,
	input wire logic              fully_functional
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic quiet;
	// No event this cycle, so nothing can set a flag at the next edge
	assign quiet = !rx_loss_event && !tx_fault_event && other_flag_event == '0;
	chk_rx_flag: assert property (rx_loss_event |=> flag_status[0])
		else $error("rx flag not set");
	chk_int_on: assert property ((flag_status & ~flag_mask) != 0 && !flag_read_done
		|=> !interrupt_out_n) else $error("int not low");
	chk_int_off: assert property (fully_functional && quiet && (flag_status & ~flag_mask) == 0
		|=> interrupt_out_n) else $error("int not high");
	chk_flag_clear: assert property (flag_read_done && quiet |=> flag_status == 0)
		else $error("flags not cleared");
	chk_set_wins: assert property (flag_read_done && tx_fault_event |=> flag_status[1])
		else $error("set lost to clear");
	chk_pdown_entry: assert property ($rose(power_down_bit) && fully_functional
		|-> ##[1:4] low_power) else $error("no power down");
	chk_sel_on: assert property ($fell(module_select_n) && fully_functional
		|-> ##[1:8] serial_bus_enable) else $error("bus not on");
	chk_sel_off: assert property ($rose(module_select_n) |-> ##[1:8] !serial_bus_enable)
		else $error("bus not off");
	chk_init_done: assert property ($fell(data_not_ready) |-> fully_functional
		&& !interrupt_out_n) else $error("bad ready");
	cover property ($fell(data_not_ready));
	cover property (flag_read_done);
	cover property (flag_read_done && tx_fault_event);
	cover property ($rose(low_power));
endmodule // mmc_asserts
bind mmc_control mmc_asserts #(.FLAG_W(FLAG_W)) mmc_asserts_i (.*);

// ### sim/mmc_host.sv
// Host pin model: reset, select and low-power pins
`timescale 1ns/10ps
module mmc_host (
	input  wire logic clk_sys,
	output logic      module_reset_n,
	output logic      module_select_n,
	output logic      low_power_pin
);
	initial {module_reset_n, module_select_n, low_power_pin} = 3'h6;
	task automatic pins(input logic s, l);
		module_select_n = s;
		low_power_pin = l;
	endtask
	// Short pulses allowed here to probe the qualification window
	task automatic rst_pulse(input int n);
		module_reset_n = 1'h0;
		repeat (n) @(negedge clk_sys);
		module_reset_n = 1'h1;
	endtask
endmodule // mmc_host

// ### sim/testbench.sv
// Self-checking bench for the management control block
`timescale 1ns/10ps
module testbench;
	logic clk_sys = 0, reset = 1, rx_loss_event = 0, tx_fault_event = 0;
	logic flag_read_done = 0, power_down_bit = 0, module_reset_n, low_power_pin;
	logic [5:0] other_flag_event = 0;
	logic [7:0] flag_mask = 0, flag_status, expf;
	logic module_select_n, interrupt_out_n, data_not_ready, low_power;
	logic serial_bus_enable, fully_functional;
	logic [16:0] r = 17'h11C79;
	int n_mismatch = 0, checks_done = 0, c;
	mmc_control #(.INIT_CYCLES(100), .PUP_CYCLES(50)) mmc_control_i (.*);
	mmc_host mmc_host_i (.*);
	initial forever #25 clk_sys = ~clk_sys;
	task automatic chk(input string n, input logic [7:0] s, e);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	function automatic logic [16:0] lfsr(input logic [16:0] v);
		return {v[15:0], v[16] ^ v[13]};
	endfunction
	task automatic cyc(input int k);
		repeat (k) @(negedge clk_sys);
	endtask
	// Bounded wait; a hang ends the run
	task automatic wait_ff(output int n);
		n = 0;
		while (fully_functional !== 1'h1) begin
			cyc(1);
			if (++n > 1000) begin n_mismatch++; end_sim; end
		end
	endtask
	initial begin
		cyc(6);
		reset = 0;
		wait_ff(c);
		chk("init", c <= 102, 1);
		chk("int", interrupt_out_n, 0);
		chk("nrdy", data_not_ready, 0);
		mmc_host_i.pins(0, 0);
		cyc(8);
		chk("bus", serial_bus_enable, 1);
		mmc_host_i.pins(1, 0);
		cyc(8);
		chk("bus", serial_bus_enable, 0);
		$display("test init/select done");
		expf = 0;
		for (int i = 0; i < 8; i++) begin
			r = lfsr(r);
			flag_mask = r[7:0];
			{other_flag_event, tx_fault_event, rx_loss_event} = 8'h01 << i;
			expf |= 8'h01 << i;
			cyc(1);
			{other_flag_event, tx_fault_event, rx_loss_event} = 0;
			cyc(1);
			chk("flags", flag_status, expf);
			chk("int", interrupt_out_n, (expf & ~flag_mask) == 0);
		end
		flag_mask = 8'hFF;
		cyc(2);
		chk("int", interrupt_out_n, 1);
		flag_mask = 0;
		cyc(2);
		chk("int", interrupt_out_n, 0);
		flag_read_done = 1;
		tx_fault_event = 1;
		cyc(1);
		flag_read_done = 0;
		tx_fault_event = 0;
		cyc(1);
		chk("flags", flag_status, 8'h02);
		chk("int", interrupt_out_n, 0);
		flag_read_done = 1;
		cyc(1);
		flag_read_done = 0;
		cyc(1);
		chk("flags", flag_status, 0);
		chk("int", interrupt_out_n, 1);
		$display("test flags done");
		power_down_bit = 1;
		cyc(4);
		chk("lp", low_power, 1);
		power_down_bit = 0;
		cyc(5);
		power_down_bit = 1;
		cyc(2);
		chk("lp", low_power, 1);
		chk("ff", fully_functional, 0);
		power_down_bit = 0;
		wait_ff(c);
		chk("wake", c <= 58, 1);
		mmc_host_i.pins(1, 1);
		cyc(8);
		chk("lp", low_power, 1);
		mmc_host_i.pins(1, 0);
		wait_ff(c);
		mmc_host_i.rst_pulse(20);
		cyc(4);
		chk("ff", fully_functional, 1);
		mmc_host_i.rst_pulse(60);
		cyc(4);
		chk("nrdy", data_not_ready, 1);
		wait_ff(c);
		chk("init", c <= 102, 1);
		chk("int", interrupt_out_n, 0);
		$display("test power/reset done");
		end_sim;
	end
endmodule // testbench
